// File: verilog/adc_input_and_gain_config.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adc_input_and_gain_config
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS = 12,
  parameter int MOD_DIV  = MOD_DIV_CYCLES
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // analog front end controls
  output adc_cfg_pkg::mux_cfg_type    muxCfg,
  output adc_cfg_pkg::amp_cfg_type    ampCfg,
  output logic                        ampActive,
  output logic [7:0]                  ampGainFactor,
  output logic                        selInvalid,
  // conversion sequencer handshake
  output logic                        filterReset,
  output logic                        settleBusy,
  output logic                        convStart
);
  import adc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a code is usable if it names a fitted input or the common input
  function automatic logic sel_ok(input logic [3:0] code);
    if (code == SEL_COMMON) begin
      sel_ok = 1'b1;
    end else if (code > SEL_LAST_ANALOG) begin
      sel_ok = 1'b0;
    end else if (CHANNELS < 12 && code >= SEL_FIRST_HIGH) begin
      sel_ok = 1'b0;
    end else begin
      sel_ok = 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]              inputPairSel_ff;
  logic [7:0]              nxt_inputPairSel;
  logic [7:0]              ampGainCfg_ff;
  logic [7:0]              nxt_ampGainCfg;
  logic [31:0]             prdata_ff;
  logic [31:0]             nxt_prdata;
  logic                    pready_ff;
  logic                    nxt_pready;
  logic                    pslverr_ff;
  logic                    nxt_pslverr;

  mux_cfg_type             muxCfg_ff;
  mux_cfg_type             nxt_muxCfg;
  amp_cfg_type             ampCfg_ff;
  amp_cfg_type             nxt_ampCfg;
  logic                    ampActive_ff;
  logic                    nxt_ampActive;
  logic [7:0]              ampGainFactor_ff;
  logic [7:0]              nxt_ampGainFactor;
  logic                    selInvalid_ff;
  logic                    nxt_selInvalid;

  seq_state_type           seqState_ff;
  seq_state_type           nxt_seqState;
  logic                    filterReset_ff;
  logic                    nxt_filterReset;
  logic                    settleBusy_ff;
  logic                    nxt_settleBusy;
  logic                    convStart_ff;
  logic                    nxt_convStart;

  logic                    setupPhase;
  logic                    accessDone;
  logic                    hitInput;
  logic                    hitAmp;
  logic                    hitStatus;
  logic                    cfgWrite;
  logic                    timerLoad;
  logic                    modTick;
  logic                    delayDone;
  logic [DELAY_CNT_W-1:0]  delayRemaining;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready_ff;
  assign hitInput   = (paddr == byte_addr(IDX_INPUT_PAIR_SELECT));
  assign hitAmp     = (paddr == byte_addr(IDX_AMP_GAIN_CONFIG));
  assign hitStatus  = (paddr == byte_addr(IDX_SETTLE_STATUS));

  // any write to either register with byte 0 strobed resets the filter
  assign cfgWrite   = accessDone && pwrite && pstrb[0] && (hitInput || hitAmp);
  assign timerLoad  = cfgWrite;

  // ----------------------------------------------------------------
  // bus answer: one wait-free access phase, data set up during setup
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pready  = setupPhase;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (setupPhase) begin
      nxt_prdata = 32'h0000_0000;
      if (hitInput) begin
        nxt_prdata[7:0] = inputPairSel_ff;
      end else if (hitAmp) begin
        nxt_prdata[7:0] = ampGainCfg_ff;
      end else if (hitStatus && !pwrite) begin
        nxt_prdata[ST_BUSY]    = settleBusy_ff;
        nxt_prdata[ST_BAD_SEL] = selInvalid_ff;
        nxt_prdata[ST_BAD_AMP] = ampCfg_ff.power[1];
        nxt_prdata[ST_CNT_LO +: DELAY_CNT_W] = delayRemaining;
      end else begin
        // unmapped address, or a write to the read-only status word
        nxt_pslverr = 1'b1;
      end
    end else if (accessDone) begin
      nxt_prdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_inputPairSel = inputPairSel_ff;
    nxt_ampGainCfg   = ampGainCfg_ff;
    if (accessDone && pwrite && pstrb[0]) begin
      // reserved codes are stored so software reads back what it wrote
      if (hitInput) begin
        nxt_inputPairSel = pwdata[7:0];
      end
      if (hitAmp) begin
        nxt_ampGainCfg = pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // front end decode
  // ----------------------------------------------------------------
  always_comb begin
    nxt_muxCfg.pos     = inputPairSel_ff[POS_SEL_HI:POS_SEL_LO];
    nxt_muxCfg.neg     = inputPairSel_ff[NEG_SEL_HI:NEG_SEL_LO];
    nxt_ampCfg.power   = ampGainCfg_ff[AMP_PWR_HI:AMP_PWR_LO];
    nxt_ampCfg.gain    = ampGainCfg_ff[GAIN_HI:GAIN_LO];
    nxt_ampActive      = (nxt_ampCfg.power == AMP_ENABLED);
    // reserved power codes leave the amplifier off, as the safer state
    if (nxt_ampActive) begin
      nxt_ampGainFactor = 8'h01 << nxt_ampCfg.gain;
    end else begin
      // bypass forces unity gain whatever the gain code holds
      nxt_ampGainFactor = 8'h01;
    end
    nxt_selInvalid = !sel_ok(nxt_muxCfg.pos) || !sel_ok(nxt_muxCfg.neg);
  end

  // ----------------------------------------------------------------
  // settling sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_seqState    = seqState_ff;
    nxt_filterReset = cfgWrite;
    nxt_convStart   = 1'b0;
    case (seqState_ff)
      SEQ_IDLE: begin
        if (cfgWrite) begin
          nxt_seqState = SEQ_SETTLE;
        end
      end
      SEQ_SETTLE: begin
        // a fresh write restarts the wait through the timer reload
        if (delayDone && !cfgWrite) begin
          nxt_seqState  = SEQ_START;
          nxt_convStart = 1'b1;
        end
      end
      SEQ_START: begin
        if (cfgWrite) begin
          nxt_seqState = SEQ_SETTLE;
        end else begin
          nxt_seqState = SEQ_IDLE;
        end
      end
      default: begin
        nxt_seqState = SEQ_IDLE;
      end
    endcase
    nxt_settleBusy = (nxt_seqState == SEQ_SETTLE);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inputPairSel_ff  <= RST_INPUT_PAIR_SELECT;
      ampGainCfg_ff    <= RST_AMP_GAIN_CONFIG;
      prdata_ff        <= 32'h0000_0000;
      pready_ff        <= 1'b0;
      pslverr_ff       <= 1'b0;
      muxCfg_ff        <= mux_cfg_type'(RST_INPUT_PAIR_SELECT);
      ampCfg_ff        <= amp_cfg_type'(5'h00);
      ampActive_ff     <= 1'b0;
      ampGainFactor_ff <= 8'h01;
      selInvalid_ff    <= 1'b0;
      seqState_ff      <= SEQ_IDLE;
      filterReset_ff   <= 1'b0;
      settleBusy_ff    <= 1'b0;
      convStart_ff     <= 1'b0;
    end else begin
      inputPairSel_ff  <= nxt_inputPairSel;
      ampGainCfg_ff    <= nxt_ampGainCfg;
      prdata_ff        <= nxt_prdata;
      pready_ff        <= nxt_pready;
      pslverr_ff       <= nxt_pslverr;
      muxCfg_ff        <= nxt_muxCfg;
      ampCfg_ff        <= nxt_ampCfg;
      ampActive_ff     <= nxt_ampActive;
      ampGainFactor_ff <= nxt_ampGainFactor;
      selInvalid_ff    <= nxt_selInvalid;
      seqState_ff      <= nxt_seqState;
      filterReset_ff   <= nxt_filterReset;
      settleBusy_ff    <= nxt_settleBusy;
      convStart_ff     <= nxt_convStart;
    end
  end

  // ----------------------------------------------------------------
  // modulator period source and delay counter
  // ----------------------------------------------------------------
  // divider only runs while settling so each wait starts on a whole period
  mod_tick_divider #(
    .DIV (MOD_DIV)
  ) u_mod_tick (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (settleBusy_ff && !timerLoad),
    .tick    (modTick)
  );

  conv_delay_timer u_delay (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .load      (timerLoad),
    .delayCode (nxt_ampGainCfg[DELAY_HI:DELAY_LO]),
    .tick      (modTick),
    .done      (delayDone),
    .remaining (delayRemaining)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign muxCfg        = muxCfg_ff;
  assign ampCfg        = ampCfg_ff;
  assign ampActive     = ampActive_ff;
  assign ampGainFactor = ampGainFactor_ff;
  assign selInvalid    = selInvalid_ff;
  assign filterReset   = filterReset_ff;
  assign settleBusy    = settleBusy_ff;
  assign convStart     = convStart_ff;

endmodule
`default_nettype wire

// File: pkg/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // register map: printed indices, byte address is four times index
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_INPUT_PAIR_SELECT = 8'h02;
  localparam logic [7:0]  IDX_AMP_GAIN_CONFIG   = 8'h03;
  localparam logic [7:0]  IDX_SETTLE_STATUS     = 8'h10;

  localparam logic [7:0]  RST_INPUT_PAIR_SELECT = 8'h01;
  localparam logic [7:0]  RST_AMP_GAIN_CONFIG   = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_SEL_HI   = 7;
  localparam int POS_SEL_LO   = 4;
  localparam int NEG_SEL_HI   = 3;
  localparam int NEG_SEL_LO   = 0;
  localparam int DELAY_HI     = 7;
  localparam int DELAY_LO     = 5;
  localparam int AMP_PWR_HI   = 4;
  localparam int AMP_PWR_LO   = 3;
  localparam int GAIN_HI      = 2;
  localparam int GAIN_LO      = 0;

  // status word layout
  localparam int ST_BUSY      = 0;
  localparam int ST_BAD_SEL   = 8;
  localparam int ST_BAD_AMP   = 9;
  localparam int ST_CNT_LO    = 16;

  // ----------------------------------------------------------------
  // input and amplifier codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_LAST_ANALOG = 4'hb;
  localparam logic [3:0] SEL_FIRST_HIGH  = 4'h6;
  localparam logic [3:0] SEL_COMMON      = 4'hc;
  localparam logic [1:0] AMP_BYPASS      = 2'h0;
  localparam logic [1:0] AMP_ENABLED     = 2'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS   = 50;
  localparam int MOD_PERIOD_NS   = 3906;
  localparam int MOD_DIV_CYCLES  = MOD_PERIOD_NS / SYS_PERIOD_NS;
  localparam int DELAY_CNT_W     = 13;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_START  = 2'b10
  } seq_state_type;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
  } mux_cfg_type;

  typedef struct packed {
    logic [1:0] power;
    logic [2:0] gain;
  } amp_cfg_type;

  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction

  // settling wait in modulator periods for each delay code
  function automatic logic [DELAY_CNT_W-1:0] delay_ticks(input logic [2:0] code);
    case (code)
      3'h0:    delay_ticks = 13'h000e;
      3'h1:    delay_ticks = 13'h0019;
      3'h2:    delay_ticks = 13'h0040;
      3'h3:    delay_ticks = 13'h0100;
      3'h4:    delay_ticks = 13'h0400;
      3'h5:    delay_ticks = 13'h0800;
      3'h6:    delay_ticks = 13'h1000;
      default: delay_ticks = 13'h0001;
    endcase
  endfunction

endpackage

// File: verilog/mod_tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
module mod_tick_divider #(
  parameter int DIV = adc_cfg_pkg::MOD_DIV_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // control
  input  wire logic run,
  output logic      tick
);
  import adc_cfg_pkg::*;

  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic         tick_ff;
  logic         nxt_tick;

  always_comb begin
    nxt_count = count_ff;
    nxt_tick  = 1'b0;
    // restarting on each run keeps the first period whole
    if (!run) begin
      nxt_count = '0;
    end else if (count_ff == LAST) begin
      nxt_count = '0;
      nxt_tick  = 1'b1;
    end else begin
      nxt_count = count_ff + W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire

// File: verilog/conv_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module conv_delay_timer
  import adc_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // control
  input  wire logic                   load,
  input  wire logic [2:0]             delayCode,
  input  wire logic                   tick,
  output logic                        done,
  output logic [DELAY_CNT_W-1:0]      remaining
);
  import adc_cfg_pkg::*;

  logic [DELAY_CNT_W-1:0] count_ff;
  logic [DELAY_CNT_W-1:0] nxt_count;
  logic                   done_ff;
  logic                   nxt_done;

  always_comb begin
    nxt_count = count_ff;
    nxt_done  = 1'b0;
    // a new load overrides a wait in progress
    if (load) begin
      nxt_count = delay_ticks(delayCode);
    end else if (tick && count_ff != '0) begin
      nxt_count = count_ff - DELAY_CNT_W'(1);
      nxt_done  = (count_ff == DELAY_CNT_W'(1));
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

  assign done      = done_ff;
  assign remaining = count_ff;

endmodule
`default_nettype wire

// File: verif/adc_cfg_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adc_cfg_monitor
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS = 12,
  parameter int MOD_DIV  = MOD_DIV_CYCLES
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // front end and sequencer
  input wire mux_cfg_type muxCfg,
  input wire amp_cfg_type ampCfg,
  input wire logic        ampActive,
  input wire logic [7:0]  ampGainFactor,
  input wire logic        selInvalid,
  input wire logic        filterReset,
  input wire logic        settleBusy,
  input wire logic        convStart
);
  // window for a one-period delay, allowing tick phase slack
  localparam int SHORT_MAX = 2 * MOD_DIV + 6;
  logic acc;
  logic cfgWr;
  assign acc   = psel & penable & pready;
  assign cfgWr = acc & pwrite & pstrb[0] & (paddr == 12'h008 | paddr == 12'h00c);

  function automatic logic bad_code(input logic [3:0] c);
    bad_code = (c > 4'hc) || (CHANNELS < 12 && c >= 4'h6 && c <= 4'hb);
  endfunction

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence sq_short_wr;
    cfgWr && paddr == 12'h00c && pwdata[7:5] == 3'h7;
  endsequence
  sequence sq_start_soon;
    ##[2:SHORT_MAX] convStart;
  endsequence

  AST_PREADY_FIRST: assert property (psel && penable && !$past(penable) |-> pready)
    else $error("no answer in first access cycle");
  AST_PREADY_ONE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside a single access cycle");
  // the front-end copy trails the register by one more cycle than the write commit
  AST_MUX_WRITE: assert property (cfgWr && paddr == 12'h008 |-> ##2 muxCfg == $past(pwdata[7:0], 2))
    else $error("input select not taken from write");
  AST_MUX_READ: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata == {24'h0, muxCfg})
    else $error("input select read mismatch");
  AST_AMP_WRITE: assert property (cfgWr && paddr == 12'h00c |-> ##2 ampCfg == $past(pwdata[4:0], 2))
    else $error("amplifier fields not taken from write");
  AST_AMP_ACTIVE: assert property (ampActive == (ampCfg.power == AMP_ENABLED))
    else $error("amplifier power state wrong");
  AST_GAIN_FACTOR: assert property (ampGainFactor == (ampActive ? 8'h01 << ampCfg.gain : 8'h01))
    else $error("gain factor wrong");
  AST_SEL_INVALID: assert property (selInvalid == (bad_code(muxCfg.pos) || bad_code(muxCfg.neg)))
    else $error("invalid select flag wrong");
  AST_FILTER_RESET: assert property (cfgWr |=> filterReset && settleBusy)
    else $error("config write did not start settling");
  AST_START_PULSE: assert property (convStart |-> !settleBusy ##1 !convStart)
    else $error("start pulse malformed");
  AST_SHORT_DELAY: assert property (sq_short_wr |-> sq_start_soon)
    else $error("one period delay not honoured");
  AST_UNMAPPED: assert property (acc && !(paddr inside {12'h008, 12'h00c, 12'h040}) |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind adc_input_and_gain_config adc_cfg_monitor #(.CHANNELS(CHANNELS), .MOD_DIV(MOD_DIV)) mon (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .muxCfg(muxCfg), .ampCfg(ampCfg), .ampActive(ampActive),
  .ampGainFactor(ampGainFactor), .selInvalid(selInvalid), .filterReset(filterReset),
  .settleBusy(settleBusy), .convStart(convStart));
`default_nettype wire

// File: verif/apb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module apb_host_model (
  // clock
  input wire logic         sys_clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int hangs;
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    hangs = 0;
  end
  // the host passes select codes through as given; both builds see every code, fitted or not, so each proves its flag
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    int k;
    logic [31:0] dd;
    dd = d;
    if (wr && a == 12'h00c && d[4:3] == 2'h0) dd[2:0] = 3'h0; // bypass keeps unity gain
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= dd; pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // ready is judged at the rising edge; read data and error are taken at that same edge
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) hangs++;
    rd  = prdata;
    err = pslverr;
    // released bus shows no stale request
    psel <= 1'b0; penable <= 1'b0; paddr <= ~a; pwdata <= ~dd;
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_cfg_pkg::*;
  localparam int DIV = 2;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [7:0] ampGainFactor;
  logic ampActive, selInvalid, filterReset, settleBusy, convStart;
  logic selInvalid6;
  mux_cfg_type muxCfg;
  amp_cfg_type ampCfg;
  int badCount, compares, cyc;

  apb_host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  adc_input_and_gain_config #(.CHANNELS(12), .MOD_DIV(DIV)) dut (.sys_clk(sys_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .muxCfg(muxCfg), .ampCfg(ampCfg), .ampActive(ampActive), .ampGainFactor(ampGainFactor),
    .selInvalid(selInvalid), .filterReset(filterReset), .settleBusy(settleBusy),
    .convStart(convStart));
  // six-channel build shadows every bus write to prove the fitted-input check
  adc_input_and_gain_config #(.CHANNELS(6), .MOD_DIV(DIV)) dut6 (.sys_clk(sys_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
    .muxCfg(), .ampCfg(), .ampActive(), .ampGainFactor(),
    .selInvalid(selInvalid6), .filterReset(), .settleBusy(), .convStart());

  task stop_test();
    $display("compares %0d, mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    host.xfer(wr, a, d, s, rdat, err);
    if (host.hangs != 0) begin
      badCount++;
      stop_test();
    end
  endtask
  // counts cycles after the call until the start pulse is seen
  task wait_start();
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
      if (cyc > 12000) begin
        badCount++;
        stop_test();
      end
    end while (convStart !== 1'b1);
  endtask

  task t_reset();
    bus(1'b0, 12'h008, 32'h0, 4'hf);
    chk("select reset", 32'h01, rdat);
    chk("read no error", 32'h0, {31'h0, err});
    bus(1'b0, 12'h00c, 32'h0, 4'hf);
    chk("gain reset", 32'h00, rdat);
    chk("factor reset", 32'h01, {24'h0, ampGainFactor});
    chk("power reset", 32'h0, {31'h0, ampActive});
  endtask
  task t_mux();
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 12'h008, {24'h0, i[3:0], ~i[3:0]}, 4'hf);
      bus(1'b0, 12'h008, 32'h0, 4'hf);
      chk("select read", {24'h0, i[3:0], ~i[3:0]}, rdat);
      chk("select flag", {31'h0, i > 12 || i < 3}, {31'h0, selInvalid});
      chk("select flag six", {31'h0, !(i == 3 || i == 12)}, {31'h0, selInvalid6});
    end
    wait_start();
  endtask
  task t_gain();
    for (int g = 0; g < 8; g++) begin
      bus(1'b1, 12'h00c, {24'h0, 3'h7, AMP_ENABLED, g[2:0]}, 4'hf);
      wait_start();
      chk("gain factor", 32'h1 << g, {24'h0, ampGainFactor});
      chk("powered", 32'h1, {31'h0, ampActive});
    end
    for (int p = 0; p < 4; p++) begin
      if (p == 1) continue;
      bus(1'b1, 12'h00c, {24'h0, 3'h7, p[1:0], 3'h5}, 4'hf);
      wait_start();
      bus(1'b0, 12'h00c, 32'h0, 4'hf);
      chk("power read", {24'h0, 3'h7, p[1:0], (p == 0) ? 3'h0 : 3'h5}, rdat);
      chk("bypass factor", 32'h1, {24'h0, ampGainFactor});
    end
  endtask
  task t_delay();
    int ticks[8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 12'h00c, {24'h0, c[2:0], AMP_ENABLED, 3'h0}, 4'hf);
      @(negedge sys_clk);
      chk("filter reset", 32'h3, {30'h0, filterReset, settleBusy});
      wait_start();
      chk("delay cycles", ticks[c] * DIV + 2, cyc);
    end
  endtask
  task t_err();
    // idle status: not settling, positive code 1111 still flagged, no ticks left
    bus(1'b0, 12'h040, 32'h0, 4'hf);
    chk("status idle", 32'h0000_0100, rdat);
    bus(1'b0, 12'h014, 32'h0, 4'hf);
    chk("unmapped error", 32'h1, {31'h0, err});
    bus(1'b1, 12'h040, 32'hff, 4'hf);
    chk("status write error", 32'h1, {31'h0, err});
    bus(1'b1, 12'h008, 32'h55, 4'h0);
    bus(1'b0, 12'h008, 32'h0, 4'hf);
    chk("masked write", {24'h0, 8'hf0}, rdat);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b1;
    badCount = 0;
    compares = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_mux();
    t_gain();
    t_delay();
    t_err();
    stop_test();
  end
endmodule
`default_nettype wire
